//--- design/spi_ctrl.sv
/*
 Serial peripheral controller, master and slave, with its as-built
 quirks. Control and status are plain ports; link pins are sampled
 through two flip-flops. Assumes single-cycle strobes from software.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Slave mode never reports a transmit underrun; the shifter's leftover word is sent.
// - Mixed divisor one, polarity one, phase zero adds one extra clock pulse.
// - Enabling in slave mode raises a spurious receive-ready flag.
// - Disable is ignored while operating in slave mode.
// - Soft reset clears enable, flags, state and shifter; software reads data first.
// - Chip select 0 held with mode-fault detection on blocks every master start.
// - Disable leaves transmit-empty alone; writes while disabled are dropped.
// - A dropped write does not clear transmit-empty.
module spi_ctrl
    import spi_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               enable_cmd,
    input  wire logic               disable_cmd,
    input  wire logic               soft_reset_bit,
    input  wire logic               master_mode,
    input  wire logic               mode_fault_disable,
    input  wire logic               cs_select,
    input  wire spi_pkg::divisor_t  serial_clock_divisor0,
    input  wire spi_pkg::divisor_t  serial_clock_divisor1,
    input  wire logic [1:0]         clock_polarity_bit,
    input  wire logic [1:0]         clock_phase_bit,
    input  wire logic [1:0]         cs_hold_after_transfer,
    input  wire logic               tx_wr_strobe,
    input  wire spi_pkg::word_t     tx_data_register,
    input  wire logic               rx_rd_strobe,
    output logic [7:0]              rx_holding_register,
    output logic                    rx_ready_flag,
    output logic                    tx_empty_flag,
    output logic                    spi_enabled,
    input  wire logic               sck_in,
    output logic                    sck_out,
    output logic                    sck_oe,
    input  wire logic               mosi_in,
    output logic                    mosi_out,
    output logic                    mosi_oe,
    input  wire logic               miso_in,
    output logic                    miso_out,
    output logic                    miso_oe,
    input  wire logic               slave_select_in_n,
    output logic [1:0]              cs_out_n
);
    import spi_pkg::*;

    shift_if sh ();

    logic [SYNC_W-1:0]  meta_reg;
    logic [SYNC_W-1:0]  sync_reg;
    logic               sck_prev_reg;
    logic               nss_prev_reg;
    logic               enabled_reg;
    logic               tx_empty_reg;
    logic               rx_ready_reg;
    word_t              tx_hold_reg;
    word_t              rx_hold_reg;
    xfer_state_t        state_reg;
    logic               act_cs_reg;
    divisor_t           div_cnt_reg;
    logic [1:0]         glitch_cnt_reg;
    logic [3:0]         edge_cnt_reg;
    logic               slave_done_reg;
    logic               sck_out_reg;
    logic               oe_m_reg;
    logic               oe_s_reg;
    logic [1:0]         cs_n_reg;
    logic               sck_s, mosi_s, miso_s, nss_s;
    logic               srst, wr_ok, stall, start_fire, frame_start;
    logic               load_fire, glitch_need, tick;
    logic               lead, ev, is_lead, pha, done_fire, spurious;
    divisor_t           cur_div;
    word_t              rx_word;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two flops per pin; only the second stage is read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= SYNC_RESET;
            sync_reg <= SYNC_RESET;
        end else begin
            meta_reg <= {sck_in, mosi_in, miso_in, slave_select_in_n};
            sync_reg <= meta_reg;
        end
    end

    // Previous levels for edge detection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_reg <= 1'b0;
            nss_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s;
            nss_prev_reg <= nss_s;
        end
    end

    assign {sck_s, mosi_s, miso_s, nss_s} = sync_reg;

    // ------------------------------------------------------------
    // Decode of requests
    // ------------------------------------------------------------
    // Soft reset, write filter, start conditions and edge events
    always_comb begin
        srst        = soft_reset_bit;
        wr_ok       = tx_wr_strobe && enabled_reg;
        stall       = cs_hold_after_transfer[0]
                      && !mode_fault_disable;
        start_fire  = (state_reg == ST_IDLE) && enabled_reg && master_mode
                      && !stall && (!tx_empty_reg || wr_ok) && !srst;
        frame_start = enabled_reg && !master_mode && nss_prev_reg
                      && !nss_s && !srst;
        // Empty holding with no write keeps the old character
        load_fire   = start_fire
                      || (frame_start && (!tx_empty_reg || wr_ok));
        glitch_need = clock_polarity_bit[cs_select]
                      && !clock_phase_bit[cs_select]
                      && ((serial_clock_divisor0 == DIV_ONE)
                          != (serial_clock_divisor1 == DIV_ONE));
        cur_div     = act_cs_reg ? serial_clock_divisor1
                                 : serial_clock_divisor0;
        if (cur_div == DIV_ZERO) begin
            cur_div = DIV_ONE;
        end
        tick        = div_cnt_reg == (cur_div - DIV_ONE);
        lead        = (sck_prev_reg == clock_polarity_bit[0])
                      && (sck_s != clock_polarity_bit[0]);
        if (master_mode) begin
            pha     = clock_phase_bit[act_cs_reg];
            ev      = (state_reg == ST_SHIFT) && tick;
            is_lead = !edge_cnt_reg[0];
        end else begin
            pha     = clock_phase_bit[0];
            ev      = enabled_reg && !nss_s && (sck_prev_reg != sck_s);
            is_lead = lead;
        end
        done_fire   = master_mode ? (state_reg == ST_DONE) : slave_done_reg;
        rx_word     = pha ? sh.data : {sh.data[DATA_W-2:0], sh.cap};
        spurious    = enable_cmd && !enabled_reg && !master_mode;
    end

    // Shifter controls; phase one samples on leading edges
    always_comb begin
        sh.clear     = srst;
        sh.load      = load_fire;
        sh.load_data = tx_empty_reg ? tx_data_register : tx_hold_reg;
        sh.bit_in    = master_mode ? miso_s : mosi_s;
        sh.sample    = ev && (pha ? is_lead : !is_lead);
        sh.shift     = ev && (pha ? !is_lead
                                  : (is_lead && edge_cnt_reg != EDGE_FIRST));
    end

    // ------------------------------------------------------------
    // Enable and transmit holding
    // ------------------------------------------------------------
    // Disable is honoured only in master mode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enabled_reg <= 1'b0;
        end else if (srst) begin
            enabled_reg <= 1'b0;
        end else if (enable_cmd) begin
            enabled_reg <= 1'b1;
        end else if (disable_cmd && master_mode) begin
            enabled_reg <= 1'b0;
        end
    end

    // Empty flag is touched only by soft reset, loads and accepted writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_empty_reg <= 1'b1;
        end else if (srst) begin
            tx_empty_reg <= 1'b1;
        end else if (load_fire) begin
            tx_empty_reg <= !(wr_ok && !tx_empty_reg);
        end else if (wr_ok) begin
            tx_empty_reg <= 1'b0;
        end
    end

    // Holding word; a write taken straight into the shifter skips it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_hold_reg <= DATA_RESET;
        end else if (wr_ok && !(load_fire && tx_empty_reg)) begin
            tx_hold_reg <= tx_data_register;
        end
    end

    a_disabled_write: assert property (
        !enabled_reg && tx_wr_strobe && tx_empty_reg && !srst
        |=> tx_empty_reg)
        else $error("write while disabled cleared transmit-empty");

    a_disable_keeps_empty: assert property (
        disable_cmd && master_mode && !load_fire && !wr_ok && !srst
        |=> tx_empty_reg == $past(tx_empty_reg))
        else $error("disable changed transmit-empty");

    a_slave_disable_ign: assert property (
        enabled_reg && !master_mode && disable_cmd && !srst
        |=> enabled_reg)
        else $error("disable acted in slave mode");

    a_soft_reset_clr: assert property (
        srst |=> !enabled_reg && tx_empty_reg && !rx_ready_reg
                 && state_reg == ST_IDLE)
        else $error("soft reset left state behind");

    // ------------------------------------------------------------
    // Master sequencer
    // ------------------------------------------------------------
    // Idle, optional extra pulse, sixteen edges, then completion
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else if (srst || !enabled_reg) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_fire) begin
                        state_reg <= glitch_need ? ST_GLITCH : ST_SHIFT;
                    end
                end
                ST_GLITCH: begin
                    if (tick && glitch_cnt_reg == GLITCH_LAST) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (ev && edge_cnt_reg == EDGE_LAST) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Chip select in use and divider count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_cs_reg  <= 1'b0;
            div_cnt_reg <= DIV_ZERO;
        end else if (start_fire) begin
            act_cs_reg  <= cs_select;
            div_cnt_reg <= DIV_ZERO;
        end else begin
            div_cnt_reg <= tick ? DIV_ZERO : div_cnt_reg + DIV_ONE;
        end
    end

    // Extra-pulse half periods
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            glitch_cnt_reg <= GLITCH_INIT;
        end else if (start_fire) begin
            glitch_cnt_reg <= GLITCH_INIT;
        end else if (state_reg == ST_GLITCH && tick) begin
            glitch_cnt_reg <= glitch_cnt_reg + 2'h1;
        end
    end

    // Edge count for both modes; slave restarts with its select
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_cnt_reg   <= EDGE_FIRST;
            slave_done_reg <= 1'b0;
        end else begin
            slave_done_reg <= !master_mode && ev
                              && edge_cnt_reg == EDGE_LAST && !srst;
            if (srst || start_fire || frame_start
                || (!master_mode && nss_s)) begin
                edge_cnt_reg <= EDGE_FIRST;
            end else if (ev) begin
                edge_cnt_reg <= edge_cnt_reg + 4'h1;
            end
        end
    end

    // Clock and chip select pins of the master
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_out_reg <= 1'b0;
            cs_n_reg    <= CS_ALL_OFF;
        end else begin
            if (state_reg == ST_IDLE) begin
                sck_out_reg <= clock_polarity_bit[cs_select];
            end else if ((state_reg == ST_GLITCH || state_reg == ST_SHIFT)
                         && tick) begin
                sck_out_reg <= !sck_out_reg;
            end
            if (srst || !enabled_reg || !master_mode) begin
                cs_n_reg <= CS_ALL_OFF;
            end else if (start_fire) begin
                cs_n_reg <= ~(CS_ONE << cs_select);
            end else if (state_reg == ST_DONE
                         && !cs_hold_after_transfer[act_cs_reg]) begin
                cs_n_reg <= CS_ALL_OFF;
            end
        end
    end

    sequence s_glitch_start;
        start_fire && glitch_need;
    endsequence
    sequence s_glitch_body;
        (state_reg == ST_GLITCH) [*2];
    endsequence
    a_extra_pulse: assert property (
        s_glitch_start |=> s_glitch_body)
        else $error("extra clock pulse missing");

    a_held_cs_stall: assert property (
        state_reg == ST_IDLE && master_mode && stall |=> state_reg == ST_IDLE)
        else $error("transfer started with held select and fault on");

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    // Set wins over the read that clears the flag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_ready_reg <= 1'b0;
            rx_hold_reg  <= DATA_RESET;
        end else if (srst) begin
            rx_ready_reg <= 1'b0;
        end else begin
            if (done_fire) begin
                rx_hold_reg <= rx_word;
            end
            if (done_fire || spurious) begin
                rx_ready_reg <= 1'b1;
            end else if (rx_rd_strobe) begin
                rx_ready_reg <= 1'b0;
            end
        end
    end

    a_slave_glitch: assert property (
        spurious && !srst |=> rx_ready_reg)
        else $error("slave enable did not raise receive-ready");

    a_rx_done_sets: assert property (
        done_fire && !srst
        |=> rx_ready_reg && rx_hold_reg == $past(rx_word))
        else $error("completed word not delivered");

    spi_shifter u_shifter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .sh       (sh)
    );

    // Output drive straight from flops
    assign rx_holding_register = rx_hold_reg;
    assign rx_ready_flag       = rx_ready_reg;
    assign tx_empty_flag       = tx_empty_reg;
    assign spi_enabled         = enabled_reg;
    assign sck_out             = sck_out_reg;
    assign sck_oe              = oe_m_reg;
    assign mosi_out            = sh.bit_out;
    assign mosi_oe             = oe_m_reg;
    assign miso_out            = sh.bit_out;
    assign miso_oe             = oe_s_reg;
    assign cs_out_n            = cs_n_reg;

    // Pin enables: master drives clock and data out, slave its reply
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_m_reg <= 1'b0;
            oe_s_reg <= 1'b0;
        end else begin
            oe_m_reg <= enabled_reg && master_mode && !srst;
            oe_s_reg <= enabled_reg && !master_mode && !nss_s && !srst;
        end
    end
endmodule : spi_ctrl

//--- include/spi_pkg.sv
/*
 Constants, types and state codes shared by the serial controller files.
 Assumes an 8-bit character and two chip selects.
*/
package spi_pkg;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int              DATA_W      = 8;
    localparam int              DIV_W       = 8;
    localparam int              NUM_CS      = 2;
    localparam int              SYNC_W      = 4;
    localparam logic [3:0]      EDGE_LAST   = 4'hf;
    localparam logic [3:0]      EDGE_FIRST  = 4'h0;
    localparam logic [1:0]      GLITCH_LAST = 2'h1;
    localparam logic [1:0]      GLITCH_INIT = 2'h0;
    localparam logic [7:0]      DIV_ONE     = 8'h01;
    localparam logic [7:0]      DIV_ZERO    = 8'h00;
    localparam logic [7:0]      DATA_RESET  = 8'h00;
    localparam logic [1:0]      CS_ALL_OFF  = 2'h3;
    localparam logic [1:0]      CS_ONE      = 2'h1;
    // Sync order {sck, mosi, miso, select_n}; select idles high
    localparam logic [3:0]      SYNC_RESET  = 4'h1;

    typedef logic [DATA_W-1:0]  word_t;
    typedef logic [DIV_W-1:0]   divisor_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_GLITCH = 2'b01,
        ST_SHIFT  = 2'b10,
        ST_DONE   = 2'b11
    } xfer_state_t;
endpackage : spi_pkg

//--- include/shift_if.sv
/*
 Link between the controller and its character shifter.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface shift_if;
    import spi_pkg::*;
    logic   clear;
    logic   load;
    word_t  load_data;
    logic   sample;
    logic   bit_in;
    logic   shift;
    logic   bit_out;
    logic   cap;
    word_t  data;

    modport ctrl    (output clear, load, load_data, sample, bit_in, shift,
                     input  bit_out, cap, data);
    modport shifter (input  clear, load, load_data, sample, bit_in, shift,
                     output bit_out, cap, data);
endinterface : shift_if

//--- design/spi_shifter.sv
/*
 Character shift register with a one-bit capture stage.
 Assumes the controller never asks for load and shift together
 with a meaning other than load first.
*/
`timescale 1ns/10ps
module spi_shifter
    import spi_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   reset_n,
    shift_if.shifter    sh
);
    word_t  sr_reg;
    logic   cap_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    // Load wins over shift; sampled bit enters on the shift edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_reg <= DATA_RESET;
        end else if (sh.clear) begin
            sr_reg <= DATA_RESET;
        end else if (sh.load) begin
            sr_reg <= sh.load_data;
        end else if (sh.shift) begin
            sr_reg <= {sr_reg[DATA_W-2:0], cap_reg};
        end
    end

    // Capture stage holds the line level between the two edges
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_reg <= 1'b0;
        end else if (sh.sample) begin
            cap_reg <= sh.bit_in;
        end
    end

    assign sh.bit_out = sr_reg[DATA_W-1];
    assign sh.cap     = cap_reg;
    assign sh.data    = sr_reg;

    a_load_takes_word: assert property (
        sh.load && !sh.clear |=> sh.data == $past(sh.load_data))
        else $error("shifter did not take the loaded word");

    a_shift_moves_bit: assert property (
        sh.shift && !sh.load && !sh.clear
        |=> sh.data == {$past(sh.data[DATA_W-2:0]), $past(sh.cap)})
        else $error("shifter did not move the captured bit in");
endmodule : spi_shifter

//--- test/spi_far_end.sv
/*
 Far-side model: a slave on chip select 0 in master tests, a master
 in slave tests. Assumes polarity 0, phase 1 and a 48 ns link clock.
*/
`timescale 1ns/10ps
module spi_far_end
    import spi_pkg::*;
(
    input  wire logic   sel_n,
    input  wire logic   m_sck,
    input  wire logic   m_mosi,
    output logic        miso,
    input  wire logic   go,
    input  wire word_t  go_data,
    input  wire word_t  reply,
    input  wire logic   s_miso,
    output logic        sck,
    output logic        mosi,
    output logic        ss_n,
    output word_t       seen
);
    import spi_pkg::*;
    word_t sh;
    // ------------------------------------------------------------
    // Link behaviour
    // ------------------------------------------------------------
    // Idle link: clock still, select high
    initial begin
        {sck, mosi, ss_n, miso} = 4'h2;
        seen = 8'h00;
    end
    // Reply leaves MSB first; a released line shows the inverse
    always @(negedge sel_n) {miso, sh} = {reply[7], reply};
    always @(posedge sel_n) miso = ~miso;
    always @(negedge m_sck) if (!sel_n) {miso, sh} = {sh[6], sh << 1};
    always @(posedge m_sck) if (!sel_n) seen = {seen[6:0], m_mosi};
    // Master frame: data settles half a period before each rising edge
    always @(posedge go) begin
        ss_n = 1'b0;
        #24;
        for (int i = 7; i >= 0; i--) begin
            mosi = go_data[i];
            #24 sck = 1'b1;
            seen = {seen[6:0], s_miso};
            #24 sck = 1'b0;
        end
        mosi = ~mosi; // Held data has run out
        #24 ss_n = 1'b1;
    end
endmodule : spi_far_end

//--- test/spi_ctrl_tb.sv
/*
 Self-checking bench for spi_ctrl: master rows, then hand tests.
 Assumes spi_far_end on the link and a 200 MHz core clock.
*/
`timescale 1ns/10ps
module spi_ctrl_tb;
    import spi_pkg::*;
    logic core_clk = 0, reset_n = 0, enable_cmd = 0, disable_cmd = 0;
    logic soft_reset_bit = 0, master_mode = 1, mode_fault_disable = 1;
    logic cs_select = 0, tx_wr_strobe = 0, rx_rd_strobe = 0, go = 0;
    divisor_t serial_clock_divisor0 = 8'h04, serial_clock_divisor1 = 8'h04;
    logic [1:0] clock_polarity_bit = 2'h0, clock_phase_bit = 2'h3;
    logic [1:0] cs_hold_after_transfer = 2'h0, cs_out_n;
    word_t tx_data_register = 8'h00, reply = 8'h00, seen;
    logic [7:0] rx_holding_register;
    logic rx_ready_flag, tx_empty_flag, spi_enabled, sck_in, sck_out;
    logic sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
    logic slave_select_in_n, sck_last;
    int bad_count = 0, n_tests = 0, cycles = 0, toggles = 0;
    logic [15:0] rows [4] = '{16'h5ac3, 16'h00ff, 16'hff00, 16'ha53c};

    spi_ctrl spi_ctrl_inst (.core_clk, .reset_n, .enable_cmd, .disable_cmd,
        .soft_reset_bit, .master_mode, .mode_fault_disable, .cs_select,
        .serial_clock_divisor0, .serial_clock_divisor1, .clock_polarity_bit,
        .clock_phase_bit, .cs_hold_after_transfer, .tx_wr_strobe,
        .tx_data_register, .rx_rd_strobe, .rx_holding_register,
        .rx_ready_flag, .tx_empty_flag, .spi_enabled, .sck_in, .sck_out,
        .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out,
        .miso_oe, .slave_select_in_n, .cs_out_n);
    spi_far_end spi_far_end_inst (.sel_n(cs_out_n[0]), .m_sck(sck_out),
        .m_mosi(mosi_out), .miso(miso_in), .go, .go_data(tx_data_register),
        .reply, .s_miso(miso_out), .sck(sck_in), .mosi(mosi_in),
        .ss_n(slave_select_in_n), .seen);

    always #2.5 core_clk = ~core_clk;
    // Cycle ceiling and serial clock toggle count
    always @(posedge core_clk) begin
        cycles++;
        sck_last <= sck_out;
        if (sck_out !== sck_last) toggles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : check

    // One-cycle strobe: 0 on, 1 off, 2 reset, 3 write, 4 read, 5 frame
    task automatic hit(input int k, input word_t d = 8'h00);
        @(posedge core_clk);
        tx_data_register <= d;
        case (k)
            0: enable_cmd <= 1'b1;
            1: disable_cmd <= 1'b1;
            2: soft_reset_bit <= 1'b1;
            3: tx_wr_strobe <= 1'b1;
            4: rx_rd_strobe <= 1'b1;
            default: go <= 1'b1;
        endcase
        @(posedge core_clk);
        {enable_cmd, disable_cmd, soft_reset_bit} <= 3'h0;
        {tx_wr_strobe, rx_rd_strobe, go} <= 3'h0;
        #1;
    endtask : hit

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    task automatic wait_rx;
        int n;
        n = 0;
        while (rx_ready_flag !== 1'b1 && n < 400) begin
            idle(1);
            n++;
        end
        check(8'(n < 400), 8'h01);
    endtask : wait_rx

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Main sequence: reset, rows, then awkward cases
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        check(tx_empty_flag, 1);
        check(cs_out_n, 2'h3);
        repeat (3) hit(3, 8'h11);
        check(tx_empty_flag, 1);
        hit(0);
        idle(10);
        check(cs_out_n, 2'h3);
        check(sck_oe, 1);
        check(mosi_oe, 1);
        check(miso_oe, 0);
        $display("test reset and dropped writes done");
        foreach (rows[i]) begin
            reply = rows[i][7:0];
            hit(3, rows[i][15:8]);
            wait_rx;
            check(rx_holding_register, rows[i][7:0]);
            check(seen, rows[i][15:8]);
            hit(4);
            check(rx_ready_flag, 0);
            $display("test row %0d done", i);
        end
        hit(3, 8'h21);
        hit(3, 8'h42);
        hit(1);
        check(spi_enabled, 0);
        check(tx_empty_flag, 0);
        hit(2);
        check(tx_empty_flag, 1);
        $display("test disable done");
        @(posedge core_clk);
        cs_hold_after_transfer <= 2'h1;
        mode_fault_disable <= 1'b0;
        reply = 8'h99;
        hit(0);
        hit(3, 8'h77);
        idle(40);
        check(cs_out_n, 2'h3);
        check(tx_empty_flag, 0);
        @(posedge core_clk);
        mode_fault_disable <= 1'b1;
        wait_rx;
        check(rx_holding_register, 8'h99);
        check(cs_out_n, 2'h2);
        hit(2);
        check(spi_enabled, 0);
        $display("test held select done");
        @(posedge core_clk);
        cs_hold_after_transfer <= 2'h0;
        clock_polarity_bit <= 2'h3;
        clock_phase_bit <= 2'h0;
        serial_clock_divisor0 <= 8'h01;
        hit(0);
        for (int d = 2; d > 0; d--) begin
            @(posedge core_clk);
            serial_clock_divisor1 <= divisor_t'(d);
            cs_select <= d == 1;
            idle(4);
            toggles = 0;
            hit(3, 8'h5a);
            check(cs_out_n, d == 1 ? 2'h1 : 2'h2);
            wait_rx;
            idle(4);
            check(8'(toggles), d == 1 ? 8'h10 : 8'h12);
            hit(4);
        end
        $display("test extra pulse done");
        hit(2);
        @(posedge core_clk);
        master_mode <= 1'b0;
        clock_polarity_bit <= 2'h0;
        clock_phase_bit <= 2'h3;
        hit(0);
        check(rx_ready_flag, 1);
        hit(1);
        check(spi_enabled, 1);
        check(miso_oe, 0);
        check(sck_oe, 0);
        @(posedge core_clk);
        clock_polarity_bit <= 2'h1;
        @(posedge core_clk);
        clock_polarity_bit <= 2'h0;
        hit(4);
        check(rx_ready_flag, 0);
        hit(3, 8'ha5);
        hit(5, 8'h3c);
        wait_rx;
        check(rx_holding_register, 8'h3c);
        check(seen, 8'ha5);
        hit(4);
        // Frame with nothing written: last shifter word goes out, no flag
        hit(5, 8'h96);
        wait_rx;
        check(rx_holding_register, 8'h96);
        check(seen, 8'h3c);
        check(tx_empty_flag, 1);
        hit(2);
        check(spi_enabled, 0);
        $display("test slave done");
        close_out;
    end
endmodule : spi_ctrl_tb
